// [bdwc_host_dma.sv]
// host slave dma channel model feeding words while the device requests them
`timescale 1ns/1ps
module bdwc_host_dma (
  // clock and reset
  input wire i_clock,
  input wire i_rst_b,
  // control from the bench
  input wire i_clear,
  input wire i_slow,
  input wire [15:0] i_base,
  // device side
  input wire i_dma_req,
  output wire o_strobe,
  output wire [15:0] o_data
);
  reg [15:0] idx_q;
  reg phase_q;
  // words move only while the request is up, paced fast or every other cycle
  assign o_strobe = i_dma_req && (!i_slow || phase_q);
  // one word per strobe; off a strobe the line shows the inverse of the next word, not the word itself
  assign o_data = o_strobe ? (i_base ^ idx_q) : ~(i_base ^ idx_q);
  // channel is armed by the bench before the opcode is written
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      idx_q <= 16'h0000;
      phase_q <= 1'b0;
    end else if (i_clear) begin
      idx_q <= 16'h0000;
    end else begin
      phase_q <= ~phase_q;
      if (o_strobe) idx_q <= idx_q + 16'h0001;
    end
  end
endmodule // bdwc_host_dma

// [bdwc_regs.vh]
// register offsets, bit positions and codes of the buffer and dma write command block
`ifndef BDWC_REGS_VH
`define BDWC_REGS_VH
// apb byte offsets, one aligned word each
`define BDWC_OFF_DATA 8'h00
`define BDWC_OFF_FEAT 8'h04
`define BDWC_OFF_SCNT 8'h08
`define BDWC_OFF_SNUM 8'h0c
`define BDWC_OFF_CYLL 8'h10
`define BDWC_OFF_CYLH 8'h14
`define BDWC_OFF_DHEAD 8'h18
`define BDWC_OFF_CMD 8'h1c
`define BDWC_OFF_ERR 8'h20
// command opcodes
`define BDWC_OP_WBUF 8'he8
`define BDWC_OP_WDMA 8'hca
`define BDWC_OP_RETRY_MASK 8'hfe
// status flag positions
`define BDWC_ST_BUSY 7
`define BDWC_ST_READY 6
`define BDWC_ST_FAULT 5
`define BDWC_ST_SEEK 4
`define BDWC_ST_DREQ 3
`define BDWC_ST_CORR 2
`define BDWC_ST_ERR 0
// error flag positions
`define BDWC_ER_CRC 7
`define BDWC_ER_UNC 6
`define BDWC_ER_IDN 4
`define BDWC_ER_ABT 2
// device/head fields
`define BDWC_DH_LBA 6
`define BDWC_DH_DRV 4
// reset values and sizes
`define BDWC_ST_RESET 8'h50
`define BDWC_DH_RESET 8'ha0
`define BDWC_SECT_WORDS 9'h100
`define BDWC_ZERO_COUNT 9'h100
`define BDWC_FIRST_SECT 8'h01
`endif

// [bdwc_top.v]
// buffer write and dma write command interpreter with its data fifo
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "bdwc_regs.vh"

// small synchronous fifo, array storage, valid/ready on both sides
module bdwc_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire i_clock,
  input wire i_rst_b,
  input wire i_flush,
  // fill side
  input wire i_in_valid,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_in_ready,
  // drain side
  output wire o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input wire i_out_ready,
  // fill level
  output wire [AW:0] o_level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] level_q;
  wire push;
  wire pop;

  assign o_in_ready = (level_q != DEPTH[AW:0]);
  assign o_out_valid = (level_q != {(AW+1){1'b0}});
  assign o_out_data = mem[rd_ptr_q];
  assign o_level = level_q;
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  // storage has no reset; only pointers and level carry state
  always @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr_q] <= i_in_data;
    end
  end

  // pointers wrap naturally since depth is a power of two
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      level_q <= {(AW+1){1'b0}};
    end else if (i_flush) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      level_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      level_q <= level_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // bdwc_fifo

module bdwc_top #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3,
  parameter SECT_PER_TRACK = 8'd63,
  parameter NUM_HEADS = 4'd15,
  parameter DRIVE_ID = 1'b0
) (
  // clock and reset
  input wire i_clock,
  input wire i_rst_b,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // host slave dma channel, same clock
  input wire i_dma_strobe,
  input wire [15:0] i_dma_data,
  input wire i_dma_crc_error,
  output reg o_dma_req,
  output reg o_intrq,
  // media write path
  output reg o_media_valid,
  output reg [15:0] o_media_data,
  input wire i_media_ready,
  input wire i_media_fail
);
  localparam ST_IDLE = 3'b001;
  localparam ST_BUFW = 3'b010;
  localparam ST_DMAW = 3'b100;

  reg [2:0] state_q;
  reg [7:0] feat_q;
  reg [7:0] scnt_q;
  reg [7:0] snum_q;
  reg [7:0] cyll_q;
  reg [7:0] cylh_q;
  reg [7:0] dhead_q;
  reg [7:0] status_q;
  reg [7:0] error_q;
  reg [15:0] sbuf [0:255];
  reg [7:0] wr_idx_q;
  reg [7:0] rd_idx_q;
  reg [8:0] sect_left_q;
  reg [16:0] rx_left_q;
  reg [8:0] tx_words_q;
  reg [27:0] cur_addr_q;

  wire setup_ph;
  wire acc_ph;
  wire wr_acc;
  wire rd_acc;
  wire push;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [15:0] fifo_out_data;
  wire [FIFO_AW:0] fifo_level;
  wire fifo_pop;
  wire media_take;
  wire sect_commit;
  wire [7:0] opcode;
  wire is_lba;
  wire [16:0] rx_left_d;

  // next sector address: plain increment in lba, sector/head/cylinder roll in chs
  function [27:0] next_addr;
    input [27:0] a;
    input lba;
    begin
      if (lba) begin
        next_addr = a + 28'h0000001;
      end else if (a[7:0] != SECT_PER_TRACK) begin
        next_addr = {a[27:8], a[7:0] + 8'h01};
      end else if (a[27:24] != NUM_HEADS) begin
        next_addr = {a[27:24] + 4'h1, a[23:8], `BDWC_FIRST_SECT};
      end else begin
        next_addr = {4'h0, a[23:8] + 16'h0001, `BDWC_FIRST_SECT};
      end
    end
  endfunction

  // apb phases; the access phase always ends in its first cycle
  assign setup_ph = i_psel & ~i_penable;
  assign acc_ph = i_psel & i_penable & o_pready;
  assign wr_acc = acc_ph & i_pwrite;
  assign rd_acc = acc_ph & ~i_pwrite;
  assign opcode = i_pwdata[7:0];
  assign is_lba = dhead_q[`BDWC_DH_LBA];

  // words enter the fifo only while the request is up
  assign push = o_dma_req & i_dma_strobe & fifo_in_ready;
  assign rx_left_d = rx_left_q - {16'h0000, push};
  assign media_take = o_media_valid & i_media_ready;
  assign fifo_pop = fifo_out_valid & (~o_media_valid | i_media_ready);
  assign sect_commit = media_take & (tx_words_q == `BDWC_SECT_WORDS - 9'h001);

  bdwc_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_flush(state_q != ST_DMAW),
    .i_in_valid(push),
    .i_in_data(i_dma_data),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_data),
    .i_out_ready(~o_media_valid | i_media_ready),
    .o_level(fifo_level)
  );

  // registered read data and zero-wait-state ready
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= setup_ph;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
      if (setup_ph) begin
        case (i_paddr)
          `BDWC_OFF_DATA: o_prdata <= {16'h0000, sbuf[rd_idx_q]};
          `BDWC_OFF_FEAT: o_prdata <= {24'h000000, feat_q};
          `BDWC_OFF_SCNT: o_prdata <= {24'h000000, scnt_q};
          `BDWC_OFF_SNUM: o_prdata <= {24'h000000, snum_q};
          `BDWC_OFF_CYLL: o_prdata <= {24'h000000, cyll_q};
          `BDWC_OFF_CYLH: o_prdata <= {24'h000000, cylh_q};
          `BDWC_OFF_DHEAD: o_prdata <= {24'h000000, dhead_q};
          `BDWC_OFF_CMD: o_prdata <= {24'h000000, status_q};
          `BDWC_OFF_ERR: o_prdata <= {24'h000000, error_q};
          default: o_pslverr <= 1'b1;
        endcase
      end
    end
  end

  // sector buffer fill by programmed writes of the data register
  always @(posedge i_clock) begin
    if (wr_acc && i_paddr == `BDWC_OFF_DATA && state_q == ST_BUFW) begin
      sbuf[wr_idx_q] <= i_pwdata[15:0];
    end
  end

  // media output stage keeps the top output straight from a flop
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_media_valid <= 1'b0;
      o_media_data <= 16'h0000;
    end else if (state_q != ST_DMAW) begin
      o_media_valid <= 1'b0;
    end else if (~o_media_valid | i_media_ready) begin
      o_media_valid <= fifo_out_valid;
      o_media_data <= fifo_out_data;
    end
  end

  // command sequencer and task file
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ST_IDLE;
      feat_q <= 8'h00;
      scnt_q <= 8'h00;
      snum_q <= 8'h00;
      cyll_q <= 8'h00;
      cylh_q <= 8'h00;
      dhead_q <= `BDWC_DH_RESET;
      status_q <= `BDWC_ST_RESET;
      error_q <= 8'h00;
      wr_idx_q <= 8'h00;
      rd_idx_q <= 8'h00;
      sect_left_q <= 9'h000;
      rx_left_q <= 17'h00000;
      tx_words_q <= 9'h000;
      cur_addr_q <= 28'h0000000;
      o_dma_req <= 1'b0;
      o_intrq <= 1'b0;
    end else begin
      // reading status acknowledges the interrupt
      if (rd_acc && i_paddr == `BDWC_OFF_CMD) begin
        o_intrq <= 1'b0;
      end
      if (rd_acc && i_paddr == `BDWC_OFF_DATA) begin
        rd_idx_q <= rd_idx_q + 8'h01;
      end
      case (state_q)
        ST_IDLE: begin
          o_dma_req <= 1'b0;
          if (wr_acc) begin
            case (i_paddr)
              `BDWC_OFF_FEAT: feat_q <= i_pwdata[7:0];
              `BDWC_OFF_SCNT: scnt_q <= i_pwdata[7:0];
              `BDWC_OFF_SNUM: snum_q <= i_pwdata[7:0];
              `BDWC_OFF_CYLL: cyll_q <= i_pwdata[7:0];
              `BDWC_OFF_CYLH: cylh_q <= i_pwdata[7:0];
              `BDWC_OFF_DHEAD: dhead_q <= i_pwdata[7:0];
              default: ;
            endcase
          end
          // commands to the other drive are not ours to answer
          if (wr_acc && i_paddr == `BDWC_OFF_CMD && dhead_q[`BDWC_DH_DRV] == DRIVE_ID) begin
            o_intrq <= 1'b0;
            error_q <= 8'h00;
            if (opcode == `BDWC_OP_WBUF) begin
              state_q <= ST_BUFW;
              wr_idx_q <= 8'h00;
              rd_idx_q <= 8'h00;
              status_q <= 8'h00;
              status_q[`BDWC_ST_READY] <= 1'b1;
              status_q[`BDWC_ST_DREQ] <= 1'b1;
            end else if ((opcode & `BDWC_OP_RETRY_MASK) == `BDWC_OP_WDMA) begin
              // zero means a full 256 sectors
              state_q <= ST_DMAW;
              sect_left_q <= (scnt_q == 8'h00) ? `BDWC_ZERO_COUNT : {1'b0, scnt_q};
              rx_left_q <= (scnt_q == 8'h00) ? {`BDWC_ZERO_COUNT, 8'h00} : {1'b0, scnt_q, 8'h00};
              tx_words_q <= 9'h000;
              cur_addr_q <= {dhead_q[3:0], cylh_q, cyll_q, snum_q};
              status_q <= 8'h00;
              status_q[`BDWC_ST_BUSY] <= 1'b1;
            end else begin
              // unsupported opcode ends at once with abort
              o_intrq <= 1'b1;
              error_q[`BDWC_ER_ABT] <= 1'b1;
              status_q <= `BDWC_ST_RESET | 8'h01;
            end
          end
        end
        ST_BUFW: begin
          // a full sector of words ends the buffer write
          if (wr_acc && i_paddr == `BDWC_OFF_DATA) begin
            wr_idx_q <= wr_idx_q + 8'h01;
            if (wr_idx_q == 8'hff) begin
              state_q <= ST_IDLE;
              o_intrq <= 1'b1;
              status_q <= `BDWC_ST_RESET;
            end
          end
        end
        ST_DMAW: begin
          rx_left_q <= rx_left_d;
          // request drops one word short of full to cover its own register delay
          o_dma_req <= (rx_left_d != 17'h00000) && (fifo_level < FIFO_DEPTH - 1);
          if (media_take) begin
            tx_words_q <= sect_commit ? 9'h000 : tx_words_q + 9'h001;
          end
          if (i_media_fail || i_dma_crc_error) begin
            // stop at the failing sector; the address names the last committed one, or the start sector if none was committed
            state_q <= ST_IDLE;
            o_dma_req <= 1'b0;
            o_intrq <= 1'b1;
            scnt_q <= sect_left_q[7:0];
            error_q[`BDWC_ER_IDN] <= i_media_fail;
            error_q[`BDWC_ER_ABT] <= 1'b1;
            error_q[`BDWC_ER_CRC] <= i_dma_crc_error;
            status_q <= `BDWC_ST_RESET | 8'h01;
          end else if (sect_commit) begin
            // report the committed sector in the request layout
            {dhead_q[3:0], cylh_q, cyll_q, snum_q} <= cur_addr_q;
            cur_addr_q <= next_addr(cur_addr_q, is_lba);
            sect_left_q <= sect_left_q - 9'h001;
            if (sect_left_q == 9'h001) begin
              state_q <= ST_IDLE;
              o_dma_req <= 1'b0;
              o_intrq <= 1'b1;
              scnt_q <= 8'h00;
              status_q <= `BDWC_ST_RESET;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // bdwc_top

// [bdwc_top_asserts.sv]
// concurrent checks on the ports of the command block
`timescale 1ns/1ps
module bdwc_top_asserts (
  // clock and reset
  input wire i_clock,
  input wire i_rst_b,
  // apb
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  // dma and media
  input wire i_dma_strobe,
  input wire [15:0] i_dma_data,
  input wire i_dma_crc_error,
  input wire o_dma_req,
  input wire o_intrq,
  input wire o_media_valid,
  input wire [15:0] o_media_data,
  input wire i_media_ready,
  input wire i_media_fail
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // one access cycle per transfer, answered right after setup
  chk_pready_next: assert property (i_psel && !i_penable |=> o_pready) else $error("pready late");
  chk_pready_only: assert property (o_pready |-> i_psel && i_penable && $past(i_psel && !i_penable))
    else $error("pready without setup");
  chk_slverr_pair: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0) else $error("bad slverr");
  chk_prdata_idle: assert property (!o_pready |-> o_prdata == 32'h0) else $error("prdata outside access");
  chk_upper_zero: assert property (o_pready && !i_pwrite |-> o_prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  // a word offered to the media waits there until taken; an error ends the command a cycle late and flushes it
  chk_media_hold: assert property (o_media_valid && !i_media_ready && !i_media_fail && !i_dma_crc_error &&
    !$past(i_media_fail) && !$past(i_dma_crc_error) |=> o_media_valid && $stable(o_media_data))
    else $error("media word dropped");
  chk_intrq_clear: assert property (o_pready && !i_pwrite && i_paddr == 8'h1c |=> !o_intrq)
    else $error("intrq kept after status read");
  chk_intrq_quiet: assert property (o_intrq |-> !o_dma_req) else $error("intrq while requesting");
  chk_fail_stop: assert property (i_media_fail && o_dma_req |-> ##[1:2] !o_dma_req ##[0:2] o_intrq)
    else $error("no stop on media fail");
endmodule // bdwc_top_asserts

// [bdwc_top_tb.sv]
// self-checking bench for the buffer and dma write command block
`timescale 1ns/1ps
`include "bdwc_regs.vh"
module bdwc_top_tb;
  logic i_clock, i_rst_b, i_psel, i_penable, i_pwrite, i_media_ready, i_media_fail, clear, slow, perr, crc;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, rd;
  logic [15:0] base;
  logic [15:0] bufw [0:255];
  logic [27:0] lba;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, o_dma_req, o_intrq, o_media_valid, dma_strobe;
  wire [15:0] o_media_data, dma_data;
  int err_count, checks_done, mcount, fail_at, n;
  bdwc_top i_dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_dma_strobe(dma_strobe), .i_dma_data(dma_data), .i_dma_crc_error(crc),
    .o_dma_req(o_dma_req), .o_intrq(o_intrq), .o_media_valid(o_media_valid), .o_media_data(o_media_data),
    .i_media_ready(i_media_ready), .i_media_fail(i_media_fail));
  bdwc_host_dma i_host (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_clear(clear), .i_slow(slow), .i_base(base),
    .i_dma_req(o_dma_req), .o_strobe(dma_strobe), .o_data(dma_data));
  // free running clock
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  task report_and_stop();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // automatic: the media sink and the main sequence both call it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      err_count++;
    end
  endtask
  // apb master: request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clock);
      k++;
    end while (o_pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      chk(32'h0, 32'h1, "apb hang");
      report_and_stop();
    end
    rd = o_prdata;
    perr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask
  // the host channel is armed before the task file and opcode are written
  task setup(input logic [7:0] cnt, sn, cl, ch, dh, op);
    base <= 16'($urandom);
    clear <= 1'b1;
    mcount = 0;
    apb(1'b1, `BDWC_OFF_SCNT, {24'h0, cnt});
    clear <= 1'b0;
    apb(1'b1, `BDWC_OFF_SNUM, {24'h0, sn});
    apb(1'b1, `BDWC_OFF_CYLL, {24'h0, cl});
    apb(1'b1, `BDWC_OFF_CYLH, {24'h0, ch});
    apb(1'b1, `BDWC_OFF_DHEAD, {24'h0, dh});
    apb(1'b1, `BDWC_OFF_CMD, {24'h0, op});
  endtask
  task wait_irq();
    int k;
    k = 0;
    while (o_intrq !== 1'b1 && k < 20000) begin
      @(posedge i_clock);
      k++;
    end
    if (k >= 20000) begin
      chk(32'h0, 32'h1, "irq hang");
      report_and_stop();
    end
  endtask
  // media sink stalls at random and checks word order; it can fail one chosen word
  always @(posedge i_clock) begin
    i_media_ready <= ($urandom % 4) != 0;
    i_media_fail <= o_media_valid && i_media_ready && (mcount + 1 == fail_at);
    if (o_media_valid && i_media_ready) begin
      chk({16'h0, o_media_data}, {16'h0, base ^ mcount[15:0]}, "media word");
      mcount++;
    end
  end
  // main sequence
  initial begin
    err_count = 0;
    checks_done = 0;
    mcount = 0;
    fail_at = 0;
    i_rst_b = 1'b0;
    {i_psel, i_penable, i_pwrite, i_media_ready, i_media_fail, slow} = 6'h00;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    clear = 1'b1;
    crc = 1'b0;
    base = 16'h0000;
    n = $urandom(44);
    repeat (3) @(posedge i_clock);
    i_rst_b <= 1'b1;
    rdchk(`BDWC_OFF_CMD, {24'h0, `BDWC_ST_RESET}, "status rst");
    rdchk(`BDWC_OFF_DHEAD, {24'h0, `BDWC_DH_RESET}, "dh rst");
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, perr}, 32'h1, "unmapped");
    apb(1'b1, `BDWC_OFF_DHEAD, 32'hb0);
    apb(1'b1, `BDWC_OFF_CMD, 32'hca);
    rdchk(`BDWC_OFF_CMD, 32'h50, "other drive");
    apb(1'b1, `BDWC_OFF_DHEAD, 32'ha0);
    mcount = 0;
    apb(1'b1, `BDWC_OFF_CMD, 32'he8);
    rdchk(`BDWC_OFF_CMD, 32'h48, "buf start");
    for (int i = 0; i < 256; i++) begin
      bufw[i] = 16'($urandom);
      apb(1'b1, `BDWC_OFF_DATA, {16'($urandom), bufw[i]});
    end
    @(posedge i_clock);
    chk({31'h0, o_intrq}, 32'h1, "buf irq");
    rdchk(`BDWC_OFF_CMD, 32'h50, "buf end");
    for (int i = 0; i < 256; i++) rdchk(`BDWC_OFF_DATA, {16'h0, bufw[i]}, "buf word");
    chk(mcount, 32'h0, "buf media");
    lba = 28'($urandom);
    setup(8'h02, lba[7:0], lba[15:8], lba[23:16], {4'he, lba[27:24]}, 8'hcb);
    wait_irq();
    chk(mcount, 32'd512, "lba words");
    lba = lba + 28'h1;
    rdchk(`BDWC_OFF_SCNT, 32'h0, "lba left");
    rdchk(`BDWC_OFF_SNUM, {24'h0, lba[7:0]}, "lba sn");
    rdchk(`BDWC_OFF_CYLL, {24'h0, lba[15:8]}, "lba cl");
    rdchk(`BDWC_OFF_CYLH, {24'h0, lba[23:16]}, "lba ch");
    apb(1'b0, `BDWC_OFF_DHEAD, 32'h0);
    chk({28'h0, rd[3:0]}, {28'h0, lba[27:24]}, "lba hd");
    rdchk(`BDWC_OFF_ERR, 32'h0, "lba err");
    rdchk(`BDWC_OFF_CMD, 32'h50, "lba st");
    slow <= 1'b1;
    fail_at = 520;
    setup(8'h00, 8'd63, 8'hff, 8'h12, 8'haf, 8'hca);
    wait_irq();
    chk({31'h0, mcount < 768}, 32'h1, "past fail");
    rdchk(`BDWC_OFF_SCNT, 32'hfe, "chs left");
    rdchk(`BDWC_OFF_SNUM, 32'h01, "chs sn");
    rdchk(`BDWC_OFF_CYLL, 32'h00, "chs cl");
    rdchk(`BDWC_OFF_CYLH, 32'h13, "chs ch");
    apb(1'b0, `BDWC_OFF_DHEAD, 32'h0);
    chk({28'h0, rd[3:0]}, 32'h0, "chs hd");
    rdchk(`BDWC_OFF_ERR, 32'h14, "chs err");
    rdchk(`BDWC_OFF_CMD, 32'h51, "chs st");
    // an opcode outside both commands ends at once with abort
    apb(1'b1, `BDWC_OFF_CMD, 32'h20);
    rdchk(`BDWC_OFF_ERR, 32'h04, "bad op err");
    chk({31'h0, o_intrq}, 32'h1, "bad op irq");
    rdchk(`BDWC_OFF_CMD, 32'h51, "bad op st");
    // interface crc error long before the first sector is committed
    setup(8'h01, 8'h05, 8'h00, 8'h00, 8'he0, 8'hca);
    repeat (20) @(posedge i_clock);
    crc <= 1'b1;
    @(posedge i_clock);
    crc <= 1'b0;
    wait_irq();
    chk({31'h0, mcount < 256}, 32'h1, "crc stop");
    rdchk(`BDWC_OFF_SCNT, 32'h01, "crc left");
    rdchk(`BDWC_OFF_SNUM, 32'h05, "crc sn");
    rdchk(`BDWC_OFF_ERR, 32'h84, "crc err");
    rdchk(`BDWC_OFF_CMD, 32'h51, "crc st");
    report_and_stop();
  end
endmodule // bdwc_top_tb

bind bdwc_top bdwc_top_asserts i_chk (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_dma_strobe(i_dma_strobe), .i_dma_data(i_dma_data),
  .i_dma_crc_error(i_dma_crc_error), .o_dma_req(o_dma_req), .o_intrq(o_intrq), .o_media_valid(o_media_valid),
  .o_media_data(o_media_data), .i_media_ready(i_media_ready), .i_media_fail(i_media_fail));
